//--- rtl/ctrl_pkg.sv
package ctrl_pkg;
	localparam int unsigned CLK_FREQ_HZ = 200_000_000;
	localparam int unsigned CLK_PERIOD_NS = 5;
	localparam int unsigned SW_FREQ_HZ = 1_200_000;

	localparam int unsigned T_OFF_NS = 2_500_000;
	localparam int unsigned T_ENTRY_DELAY_NS = 100_000;
	localparam int unsigned T_ENTRY_LOW_NS = 260_000;
	localparam int unsigned T_ENTRY_WIN_NS = 1_000_000;
	localparam int unsigned T_STEP_NS = 213_000;
	localparam int unsigned T_HALF_LIM_NS = 5_000_000;

	// Least times round up to whole cycles.
	localparam int unsigned OFF_CYC = (T_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned ENTRY_DELAY_CYC =
		(T_ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned ENTRY_LOW_CYC = (T_ENTRY_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned STEP_CYC = (T_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned HALF_LIM_CYC = (T_HALF_LIM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// The window is a longest time, so it rounds down.
	localparam int unsigned ENTRY_WIN_CYC = T_ENTRY_WIN_NS / CLK_PERIOD_NS;
	localparam int unsigned SW_PERIOD_CYC = CLK_FREQ_HZ / SW_FREQ_HZ;

	localparam int unsigned TIMER_W = 24;
	localparam int unsigned SW_CNT_W = 8;
	localparam int unsigned RAMP_W = 6;
	localparam logic [RAMP_W-1:0] RAMP_STEPS = 6'h20;
	localparam int unsigned REF_W = 5;
	localparam logic [REF_W-1:0] REF_FULL = 5'h1f;
	localparam int unsigned SYNC_W = 5;
endpackage

//--- rtl/ramp_if.sv
`timescale 1ns/1ps
interface ramp_if;
	logic run;
	logic [ctrl_pkg::RAMP_W-1:0] level;
	logic full;
	modport ctrl (output run, input level, input full);
	modport ramp (input run, output level, output full);
endinterface

//--- rtl/interval_timer.sv
`timescale 1ns/1ps
module interval_timer #(
	parameter int unsigned LIMIT = 1
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Control
	input wire logic clear,
	// Status
	output logic done
);
	localparam logic [ctrl_pkg::TIMER_W-1:0] LIM = ctrl_pkg::TIMER_W'(LIMIT);
	logic [ctrl_pkg::TIMER_W-1:0] count_q;

	// Saturates so that a long low cannot wrap back into a short one.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			count_q <= '0;
		end else if (clear) begin
			count_q <= '0;
		end else if (count_q != LIM) begin
			count_q <= count_q + 1'b1;
		end
	end

	assign done = (count_q == LIM);
endmodule

//--- rtl/softstart_ramp.sv
`timescale 1ns/1ps
module softstart_ramp #(
	parameter int unsigned STEP_CYC = ctrl_pkg::STEP_CYC
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Ramp link
	ramp_if.ramp rp
);
	localparam logic [ctrl_pkg::TIMER_W-1:0] STEP_LAST = ctrl_pkg::TIMER_W'(STEP_CYC - 1);
	logic [ctrl_pkg::TIMER_W-1:0] tick_q;

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			tick_q <= '0;
			rp.level <= '0;
		end else if (!rp.run) begin
			tick_q <= '0;
			rp.level <= '0;
		end else if (rp.level != ctrl_pkg::RAMP_STEPS) begin
			if (tick_q == STEP_LAST) begin
				tick_q <= '0;
				rp.level <= rp.level + 1'b1;
			end else begin
				tick_q <= tick_q + 1'b1;
			end
		end
	end

	assign rp.full = (rp.level == ctrl_pkg::RAMP_STEPS);

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	a_ramp_bound: assert property (rp.level <= ctrl_pkg::RAMP_STEPS)
		else $error("ramp level beyond full scale");
	a_ramp_step_rate: assert property (
		(rp.run && $past(rp.run) && rp.level != $past(rp.level))
			|-> (rp.level == $past(rp.level) + 1'b1 && $past(tick_q) == STEP_LAST))
		else $error("ramp stepped early or by more than one");
	a_ramp_hold_full: assert property ((rp.run && rp.full) |=> rp.full)
		else $error("ramp left full scale while running");
endmodule

//--- rtl/ctrl_pin_logic.sv
`timescale 1ns/1ps
module ctrl_pin_logic #(
	parameter int unsigned OFF_CYC = ctrl_pkg::OFF_CYC,
	parameter int unsigned ENTRY_DELAY_CYC = ctrl_pkg::ENTRY_DELAY_CYC,
	parameter int unsigned ENTRY_LOW_CYC = ctrl_pkg::ENTRY_LOW_CYC,
	parameter int unsigned ENTRY_WIN_CYC = ctrl_pkg::ENTRY_WIN_CYC,
	parameter int unsigned STEP_CYC = ctrl_pkg::STEP_CYC,
	parameter int unsigned HALF_LIM_CYC = ctrl_pkg::HALF_LIM_CYC
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Control pin and analog comparators
	input wire logic ctrl_pin,
	input wire logic undervoltage_lockout,
	input wire logic over_temp,
	input wire logic over_current,
	input wire logic pwm_trip,
	// Single-wire frame decoder
	input wire logic [ctrl_pkg::REF_W-1:0] wire_ref_in,
	input wire logic wire_ref_load,
	// Mode and reference
	output logic device_on,
	output logic wire_mode,
	output logic frame_accept,
	output logic ref_gate,
	output logic [ctrl_pkg::REF_W-1:0] ref_code,
	output logic [ctrl_pkg::RAMP_W-1:0] ramp_level,
	// Power stage
	output logic half_limit,
	output logic switch_on
);
	typedef enum logic {ST_OFF, ST_ON} state_t;

	////////////////////////////////////////////////////////////////////////////////
	// Input synchronisers.

	logic [ctrl_pkg::SYNC_W-1:0] meta_q;
	logic [ctrl_pkg::SYNC_W-1:0] sync_q;
	logic pin_s;
	logic undervoltage_lockout_s;
	logic ot_s;
	logic oc_s;
	logic trip_s;

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= {pwm_trip, over_current, over_temp, undervoltage_lockout, ctrl_pin};
			sync_q <= meta_q;
		end
	end

	assign pin_s = sync_q[0];
	assign undervoltage_lockout_s = sync_q[1];
	assign ot_s = sync_q[2];
	assign oc_s = sync_q[3];
	assign trip_s = sync_q[4];

	////////////////////////////////////////////////////////////////////////////////
	// Interval timers.

	state_t state_q;
	state_t state_d;
	logic off_done;
	logic delay_done;
	logic low_done;
	logic win_done;
	logic half_done;
	logic active_q;
	logic active_d;
	logic is_off;

	assign is_off = (state_q == ST_OFF);

	interval_timer #(.LIMIT(OFF_CYC)) u_off_tmr (
		.ref_clk(ref_clk),
		.reset(reset),
		.clear(pin_s || is_off),
		.done(off_done)
	);

	interval_timer #(.LIMIT(ENTRY_WIN_CYC)) u_win_tmr (
		.ref_clk(ref_clk),
		.reset(reset),
		.clear(is_off),
		.done(win_done)
	);

	interval_timer #(.LIMIT(ENTRY_DELAY_CYC)) u_delay_tmr (
		.ref_clk(ref_clk),
		.reset(reset),
		.clear(is_off),
		.done(delay_done)
	);

	// entry low counted only after delay
	interval_timer #(.LIMIT(ENTRY_LOW_CYC)) u_low_tmr (
		.ref_clk(ref_clk),
		.reset(reset),
		.clear(is_off || pin_s || !delay_done),
		.done(low_done)
	);

	interval_timer #(.LIMIT(HALF_LIM_CYC)) u_half_tmr (
		.ref_clk(ref_clk),
		.reset(reset),
		.clear(!active_q),
		.done(half_done)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Enable, shutdown and mode selection.

	logic wire_mode_q;
	logic wire_mode_d;

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_OFF: begin
				if (pin_s && !undervoltage_lockout_s) begin
					state_d = ST_ON;
				end
			end
			ST_ON: begin
				if (off_done || undervoltage_lockout_s) begin
					state_d = ST_OFF;
				end
			end
			default: begin
				state_d = ST_OFF;
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state_q <= ST_OFF;
		end else begin
			state_q <= state_d;
		end
	end

	always_comb begin
		wire_mode_d = wire_mode_q;
		if (is_off) begin
			wire_mode_d = 1'b0;
		end else if (low_done && !win_done) begin
			wire_mode_d = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			wire_mode_q <= 1'b0;
		end else begin
			wire_mode_q <= wire_mode_d;
		end
	end

	assign active_d = (state_d == ST_ON) && !undervoltage_lockout_s && !ot_s;

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			active_q <= 1'b0;
		end else begin
			active_q <= active_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Reference selection and soft start.

	logic [ctrl_pkg::REF_W-1:0] ref_code_q;
	logic ref_gate_q;
	logic frame_accept_q;
	logic half_limit_q;
	ramp_if u_ramp_if ();

	assign u_ramp_if.run = active_q;

	softstart_ramp #(.STEP_CYC(STEP_CYC)) u_ramp (
		.ref_clk(ref_clk),
		.reset(reset),
		.rp(u_ramp_if.ramp)
	);

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			ref_code_q <= ctrl_pkg::REF_FULL;
		end else if (wire_ref_load && wire_mode_q && !is_off) begin
			ref_code_q <= wire_ref_in;
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			ref_gate_q <= 1'b0;
		end else begin
			ref_gate_q <= active_d && (wire_mode_d || pin_s);
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			frame_accept_q <= 1'b0;
		end else begin
			frame_accept_q <= (state_d == ST_ON) && wire_mode_d;
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			half_limit_q <= 1'b0;
		end else begin
			half_limit_q <= active_d && !(active_q && half_done);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Switching cycle.

	localparam logic [ctrl_pkg::SW_CNT_W-1:0] SW_LAST =
		ctrl_pkg::SW_CNT_W'(ctrl_pkg::SW_PERIOD_CYC - 1);
	logic [ctrl_pkg::SW_CNT_W-1:0] sw_cnt_q;
	logic cyc_start;
	logic switch_q;

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			sw_cnt_q <= '0;
		end else if (sw_cnt_q == SW_LAST) begin
			sw_cnt_q <= '0;
		end else begin
			sw_cnt_q <= sw_cnt_q + 1'b1;
		end
	end

	assign cyc_start = (sw_cnt_q == '0);

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			switch_q <= 1'b0;
		end else if (!active_d) begin
			switch_q <= 1'b0;
		end else if (cyc_start) begin
			switch_q <= 1'b1;
		end else if (oc_s || trip_s) begin
			switch_q <= 1'b0;
		end
	end

	assign device_on = active_q;
	assign wire_mode = wire_mode_q;
	assign frame_accept = frame_accept_q;
	assign ref_gate = ref_gate_q;
	assign ref_code = ref_code_q;
	assign ramp_level = u_ramp_if.level;
	assign half_limit = half_limit_q;
	assign switch_on = switch_q;

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	sequence s_long_low;
		!is_off && off_done;
	endsequence

	a_shutdown_entry: assert property (s_long_low |=> is_off && !device_on)
		else $error("long low did not shut down");
	a_off_stays: assert property ((is_off && !pin_s) |=> is_off)
		else $error("left shutdown without a high pin");
	a_duty_default: assert property ($rose(device_on) && $past(is_off, 2) |-> !wire_mode)
		else $error("enable did not default to duty mode");
	a_window_ignore: assert property ((win_done && !wire_mode_q) |=> !wire_mode_q)
		else $error("entry accepted after window");
	a_entry_fast: assert property (
		(!is_off && low_done && !win_done) |=> wire_mode_q ##0 frame_accept_q)
		else $error("entry pattern not taken at once");
	a_mode_latch: assert property (
		(wire_mode_q && !is_off && !off_done && !undervoltage_lockout_s) |=> wire_mode_q)
		else $error("latched mode changed while on");
	// The gate goes high on the entry edge while the pin is low, so that edge is left out.
	a_chop_gate: assert property (
		(active_q && !wire_mode_q && !is_off) ##1 (active_q && !wire_mode_q)
		|-> ref_gate_q == $past(pin_s))
		else $error("reference gate does not follow pin");
	a_undervoltage_lockout_off: assert property (undervoltage_lockout_s |=> !switch_q && is_off)
		else $error("lockout did not open the switch");
	a_thermal_off: assert property (ot_s |=> !switch_q && !device_on)
		else $error("over temperature did not turn off");
	a_oc_open: assert property ((oc_s && !cyc_start) |=> !switch_q)
		else $error("overcurrent did not open the switch");
	a_cycle_close: assert property ((cyc_start && active_d) |=> switch_q)
		else $error("switch not closed at cycle start");
	a_half_window: assert property ((active_q && !half_done) ##1 active_q |-> half_limit_q)
		else $error("reduced limit missing during start");
	a_ref_load: assert property (
		(wire_ref_load && wire_mode_q && !is_off) |=> ref_code_q == $past(wire_ref_in))
		else $error("reference register not loaded");
endmodule

//--- tb/host_model.sv
`timescale 1ns/1ps
module host_model (
	// Clock
	input wire logic ref_clk,
	// Control pin
	output logic ctrl_pin
);
	// The pin starts low, as its pull-down would leave it.
	initial ctrl_pin = 1'h0;

	////////////////////////////////////////////////////////////////////////////
	// Level held for n cycles; the pin only moves on the falling edge.
	task automatic hold(input logic lvl, input int n);
		@(negedge ref_clk);
		ctrl_pin = lvl;
		repeat (n - 1) @(negedge ref_clk);
	endtask

	task automatic entry(input int dly, input int low_n);
		hold(1'h1, dly);
		hold(1'h0, low_n);
		hold(1'h1, 1);
	endtask

	// duty-cycle drive
	// Short periods keep each low far below the entry low time.
	task automatic pwm(input int hi, input int lo, input int n);
		repeat (n) begin
			hold(1'h1, hi);
			hold(1'h0, lo);
		end
	endtask
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	typedef struct packed {
		logic pin;
		logic uv;
		logic ot;
		logic on;
		logic gate;
	} row_t;
	logic ref_clk = 1'h0;
	logic reset = 1'h1;
	logic ctrl_pin;
	logic undervoltage_lockout = 1'h0;
	logic over_temp = 1'h0;
	logic over_current = 1'h0;
	logic pwm_trip = 1'h0;
	logic [ctrl_pkg::REF_W-1:0] wire_ref_in = 5'h00;
	logic wire_ref_load = 1'h0;
	logic device_on, wire_mode, frame_accept, ref_gate, half_limit, switch_on;
	logic [ctrl_pkg::REF_W-1:0] ref_code;
	logic [ctrl_pkg::RAMP_W-1:0] ramp_level;
	int error_cnt = 0;
	int total_checks = 0;
	int n;
	int w;
	row_t rows [6] = '{5'h13, 5'h02, 5'h14, 5'h13, 5'h18, 5'h13};
	logic [4:0] codes [2] = '{5'h0a, 5'h15};

	always #2.5 ref_clk = ~ref_clk;

	host_model i_host (.ref_clk(ref_clk), .ctrl_pin(ctrl_pin));

	// Counts are shortened so that the whole run stays a few thousand cycles.
	localparam int unsigned OFF_N = 200;
	localparam int unsigned DELAY_N = 20;
	localparam int unsigned LOW_N = 52;
	localparam int unsigned STEP_N = 10;
	localparam int unsigned HALF_N = 400;
	// The window equals the shutdown time, which keeps delay plus low below both.
	ctrl_pin_logic #(.OFF_CYC(OFF_N), .ENTRY_DELAY_CYC(DELAY_N), .ENTRY_LOW_CYC(LOW_N),
		.ENTRY_WIN_CYC(OFF_N), .STEP_CYC(STEP_N), .HALF_LIM_CYC(HALF_N)) i_dut (
		.ref_clk(ref_clk), .reset(reset), .ctrl_pin(ctrl_pin),
		.undervoltage_lockout(undervoltage_lockout), .over_temp(over_temp),
		.over_current(over_current), .pwm_trip(pwm_trip), .wire_ref_in(wire_ref_in),
		.wire_ref_load(wire_ref_load), .device_on(device_on), .wire_mode(wire_mode),
		.frame_accept(frame_accept), .ref_gate(ref_gate), .ref_code(ref_code),
		.ramp_level(ramp_level), .half_limit(half_limit), .switch_on(switch_on));

	////////////////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk_code(input logic [5:0] got, input logic [5:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(negedge ref_clk);
	endtask

	task automatic end_test(input string s);
		$display("test %s done", s);
	endtask

	// Waits on switch_on (sel 0) or device_on; n returns the cycles spent.
	task automatic wait_lvl(input int sel, input logic lvl, input int lim);
		n = 0;
		while ((sel == 0 ? switch_on : device_on) !== lvl) begin
			@(negedge ref_clk);
			n++;
			if (n > lim) begin
				error_cnt++;
				$display("[ERR] %0t got %h exp %h", $time, ~lvl, lvl);
				conclude();
			end
		end
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge ref_clk);
		@(negedge ref_clk);
		reset = 1'h0;
		cyc(3);
		chk_bit(device_on | wire_mode | frame_accept | switch_on, 1'h0);
		chk_code({1'h0, ref_code}, 6'h1f);
		end_test("reset");
		i_host.hold(1'h1, 1);
		wait_lvl(1, 1'h1, 10);
		cyc(5);
		chk_code(ramp_level, 6'h00);
		chk_bit(half_limit, 1'h1);
		chk_bit(wire_mode | frame_accept, 1'h0);
		cyc(150);
		chk_code(ramp_level, 6'h0f);
		cyc(170);
		chk_code(ramp_level, 6'h20);
		cyc(65);
		chk_bit(half_limit, 1'h1);
		cyc(20);
		chk_bit(half_limit, 1'h0);
		end_test("startup");
		foreach (rows[i]) begin
			undervoltage_lockout = rows[i].uv;
			over_temp = rows[i].ot;
			i_host.hold(rows[i].pin, 8);
			chk_bit(device_on, rows[i].on);
			chk_bit(ref_gate, rows[i].gate);
			if (!rows[i].on) chk_bit(switch_on, 1'h0);
		end
		wire_ref_in = 5'h0a;
		wire_ref_load = 1'h1;
		cyc(1);
		wire_ref_load = 1'h0;
		cyc(1);
		chk_code({1'h0, ref_code}, 6'h1f);
		end_test("duty rows");
		for (int k = 0; k < 2; k++) begin
			over_current = (k == 0);
			pwm_trip = (k == 1);
			wait_lvl(0, 1'h0, 400);
			wait_lvl(0, 1'h1, 400);
			wait_lvl(0, 1'h0, 8);
			w = n;
			chk_bit(w < 4, 1'h1);
			wait_lvl(0, 1'h1, 400);
			chk_bit(w + n == 166, 1'h1);
		end
		over_current = 1'h0;
		pwm_trip = 1'h0;
		cyc(340);
		chk_bit(switch_on, 1'h1);
		end_test("switching");
		i_host.hold(1'h0, 190);
		chk_bit(device_on, 1'h1);
		cyc(20);
		chk_bit(device_on | switch_on, 1'h0);
		end_test("shutdown");
		// A low begun inside the delay only counts from the end of the delay.
		i_host.entry(5, 60);
		cyc(60);
		chk_bit(wire_mode, 1'h0);
		i_host.hold(1'h0, 210);
		i_host.entry(190, 60);
		cyc(5);
		chk_bit(wire_mode, 1'h0);
		i_host.hold(1'h0, 210);
		i_host.hold(1'h1, 25);
		i_host.hold(1'h0, 45);
		chk_bit(wire_mode, 1'h0);
		cyc(15);
		chk_bit(wire_mode & frame_accept, 1'h1);
		i_host.pwm(3, 3, 20);
		chk_bit(wire_mode & ref_gate, 1'h1);
		i_host.hold(1'h1, 1);
		wire_ref_load = 1'h1;
		foreach (codes[i]) begin
			wire_ref_in = codes[i];
			cyc(1);
			chk_code({1'h0, ref_code}, {1'h0, codes[i]});
		end
		wire_ref_load = 1'h0;
		end_test("wire entry");
		i_host.hold(1'h0, 210);
		i_host.hold(1'h1, 1);
		wait_lvl(1, 1'h1, 10);
		cyc(5);
		chk_bit(wire_mode, 1'h0);
		chk_code({1'h0, ref_code}, 6'h15);
		reset = 1'h1;
		cyc(2);
		chk_code({1'h0, ref_code}, 6'h1f);
		chk_bit(device_on, 1'h0);
		end_test("restart");
		conclude();
	end

	initial begin
		repeat (20000) @(posedge ref_clk);
		error_cnt++;
		$display("[ERR] %0t got %h exp %h", $time, 1'h0, 1'h1);
		conclude();
	end
endmodule
